// *** rtl/smcu_pkg.sv ***
// constants and carrier types for the mode-register command unit
package smcu_pkg;

    // ------------------------------------------------------------------
    // command word layout
    // ------------------------------------------------------------------
    localparam logic [4:0] SMCU_MODE_REG_ADDR = 5'h0e;
    localparam logic [1:0] SMCU_KIND_PLAIN = 2'h0;
    localparam logic [1:0] SMCU_KIND_WRITE = 2'h1;
    localparam logic [1:0] SMCU_KIND_STATUS = 2'h3;
    localparam logic [6:0] SMCU_GLB_LOW = 7'h00;
    localparam int SMCU_FRAME_BITS = 16;
    localparam logic [4:0] SMCU_CNT_LAST = 5'h0f;
    localparam logic [4:0] SMCU_CNT_KIND = 5'h01;
    localparam logic [4:0] SMCU_CNT_DONE = 5'h10;

    // ------------------------------------------------------------------
    // current mode codes
    // ------------------------------------------------------------------
    localparam logic [4:0] SMCU_MODE_INIT = 5'h00;
    localparam logic [4:0] SMCU_MODE_FLASH = 5'h01;
    localparam logic [4:0] SMCU_MODE_NREQ = 5'h02;
    localparam logic [4:0] SMCU_MODE_NORMAL = 5'h03;
    localparam logic [2:0] SMCU_LP_OFF_PFX = 3'h3;

    // ------------------------------------------------------------------
    // reset values and lfsr taps
    // ------------------------------------------------------------------
    localparam logic [7:0] SMCU_LFSR_SEED = 8'h5a;
    localparam logic [7:0] SMCU_LFSR_TAPS = 8'hb8;
    localparam logic [2:0] SMCU_RND_RESET = 3'h0;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [1:0] kind;
        logic [4:0] addr;
        logic b8;
        logic b7;
        logic [6:0] low;
    } smcu_cmd_t;

    typedef struct packed {
        logic [7:0] fix;
        logic [4:0] mode;
        logic [2:0] rnd;
        logic safeOff;
        logic debug;
    } smcu_snap_t;

    typedef struct packed {
        logic [4:0] mode;
        logic lpVddOff;
        logic forced_wakeup;
        logic cyclic;
        logic rndProtect;
        logic [2:0] rndCode;
        logic [2:0] rndRead;
        logic [7:0] lfsr;
        logic safeOff;
        logic debug;
        logic [1:0] csnSync;
        logic [2:0] togSync;
        smcu_snap_t snap;
    } smcu_core_t;

    typedef struct packed {
        logic [4:0] cnt;
        logic [15:0] shift;
        logic [1:0] kind;
    } smcu_frame_t;

    typedef struct packed {
        logic tog;
        smcu_cmd_t rx;
    } smcu_done_t;

endpackage : smcu_pkg

// *** rtl/smcu_mode_cmd.sv ***
// mode-register global command interpreter behind the spi slave port
//
// Overview of operation
// - mode command: address 0x0e in bits 13-9, kind in bits 15-14 and bit 8.
// - random-code protection is chosen only in init mode, init misc bit 7.
// - in normal mode 0x1d00 or 0x1d80 returns the random code on bits 2-0.
// - protected low-power write carries inverse of last read random code.
// - unprotected 0x5c60 enters regulator-off low power, no forced wakeup or sense.
// - protected regulator-off entry is 0101 1100 0110 0 plus inverted code.
// - 0x1d00 reports mode, leaves debug, keeps safe pin.
// - 0x1d80 reports mode and releases the safe pin.
// - 0xdd00 reports mode, leaves debug, returns safe and debug bits.
// - 0xdd80 reports mode, keeps debug, releases safe, returns status bits.
// - random read answer: fixed status 15-8, mode 7-3, code 2-0.
// - mode codes: init 0, flash 1, normal request 2, normal 3, top bit low power.
// - bit 1 is 1 when safe driver off; bit 0 is 1 while debug active.
// - pending wake flags make a low-power entry wake up at once.
`timescale 1ns/1ps

module smcu_mode_cmd
    import smcu_pkg::*;
(
    // system clock and reset
    input wire logic clk,
    input wire logic resetn,
    // spi link
    input wire logic spiClk,
    input wire logic spiCsn,
    input wire logic spiMosi,
    output logic spiMiso,
    output logic spiMisoOen,
    // device-side controls
    input wire logic [7:0] fixStatus,
    input wire logic modeSetValid,
    input wire logic [4:0] modeSetCode,
    input wire logic initMiscWrite,
    input wire logic initMiscRndSel,
    input wire logic wakePending,
    input wire logic debugSet,
    input wire logic safeEngage,
    // state outputs
    output logic [4:0] currentMode,
    output logic lowPowerMode,
    output logic lpVddOff,
    output logic forcedWakeup,
    output logic cyclicSense,
    output logic safeDriverOn,
    output logic debugActive,
    output logic rndProtect
);

    // ------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------
    function automatic logic isLowPower(input logic [4:0] code);
        isLowPower = code[4] || (code[4:2] == SMCU_LP_OFF_PFX);
    endfunction : isLowPower

    function automatic logic isModeCmd(input smcu_cmd_t c);
        isModeCmd = (c.addr == SMCU_MODE_REG_ADDR);
    endfunction : isModeCmd

    // ------------------------------------------------------------------
    // link domain: frame shifter, cleared while chip select is high
    // ------------------------------------------------------------------
    smcu_frame_t frame_reg;
    smcu_frame_t frame_next;
    smcu_done_t done_reg;
    smcu_done_t done_next;
    smcu_core_t core_reg;
    smcu_core_t core_next;
    logic frameRst;
    logic [15:0] txWord;
    logic [2:0] txLow;

    assign frameRst = spiCsn || !resetn;

    always_comb begin
        frame_next = frame_reg;
        if (frame_reg.cnt != SMCU_CNT_DONE) begin
            frame_next.cnt = frame_reg.cnt + 5'h01;
            frame_next.shift = {frame_reg.shift[14:0], spiMosi};
        end
        if (frame_reg.cnt == SMCU_CNT_KIND) begin
            frame_next.kind = {frame_reg.shift[0], spiMosi};
        end
    end

    always_ff @(posedge spiClk or posedge frameRst) begin
        if (frameRst) begin
            frame_reg <= '0;
        end else begin
            frame_reg <= frame_next;
        end
    end

    // sixteenth bit completes the word; toggle tells the core
    always_comb begin
        done_next = done_reg;
        if (frame_reg.cnt == SMCU_CNT_LAST) begin
            done_next.rx = smcu_cmd_t'({frame_reg.shift[14:0], spiMosi});
            done_next.tog = !done_reg.tog;
        end
    end

    always_ff @(posedge spiClk or negedge resetn) begin
        if (!resetn) begin
            done_reg <= '0;
        end else begin
            done_reg <= done_next;
        end
    end

    // ------------------------------------------------------------------
    // answer word, built from the frozen snapshot
    // ------------------------------------------------------------------
    always_comb begin
        if (frame_reg.kind == SMCU_KIND_STATUS) begin
            txLow = {1'b0, core_reg.snap.safeOff, core_reg.snap.debug};
        end else begin
            txLow = core_reg.snap.rnd;
        end
        txWord = {core_reg.snap.fix, core_reg.snap.mode, txLow};
    end

    assign spiMiso = (frame_reg.cnt[4]) ? 1'b0 : txWord[4'hf - frame_reg.cnt[3:0]];
    assign spiMisoOen = spiCsn;

    // ------------------------------------------------------------------
    // core domain
    // ------------------------------------------------------------------
    logic newCmd;
    logic globalCmd;
    logic writeCmd;
    logic [4:0] wrCode;
    logic rndOk;
    logic lpAccept;
    smcu_cmd_t cmd;

    assign cmd = done_reg.rx;
    // rx is stable: it only moves a full frame after its toggle
    assign newCmd = core_reg.togSync[2] ^ core_reg.togSync[1];
    assign globalCmd = newCmd && isModeCmd(cmd) && cmd.b8 && (cmd.low == SMCU_GLB_LOW)
        && ((cmd.kind == SMCU_KIND_PLAIN) || (cmd.kind == SMCU_KIND_STATUS));
    assign writeCmd = newCmd && isModeCmd(cmd) && !cmd.b8 && (cmd.kind == SMCU_KIND_WRITE);
    assign wrCode = {cmd.b7, cmd.low[6:3]};
    assign rndOk = !core_reg.rndProtect || (cmd.low[2:0] == ~core_reg.rndRead);
    assign lpAccept = writeCmd && (core_reg.mode == SMCU_MODE_NORMAL) && isLowPower(wrCode)
        && rndOk;

    always_comb begin
        core_next = core_reg;
        core_next.csnSync = {core_reg.csnSync[0], spiCsn};
        core_next.togSync = {core_reg.togSync[1:0], done_reg.tog};
        core_next.lfsr = {core_reg.lfsr[6:0], ^(core_reg.lfsr & SMCU_LFSR_TAPS)};
        // global commands
        if (globalCmd) begin
            if (cmd.b7) begin
                core_next.safeOff = 1'b1;
            end else begin
                core_next.debug = 1'b0;
            end
            if (cmd.kind == SMCU_KIND_PLAIN && core_reg.mode == SMCU_MODE_NORMAL) begin
                core_next.rndRead = core_reg.rndCode;
            end
        end
        // low-power entry
        if (lpAccept) begin
            core_next.mode = {1'b1, wrCode[3:0]};
            core_next.lpVddOff = !wrCode[4];
            core_next.forced_wakeup = wrCode[4] ? wrCode[3] : wrCode[1];
            core_next.cyclic = wrCode[4] ? wrCode[2] : wrCode[0];
        end else if (writeCmd && core_reg.mode[4] && wrCode == SMCU_MODE_NREQ) begin
            core_next.mode = SMCU_MODE_NREQ;
            core_next.lpVddOff = 1'b0;
        end else if (core_reg.mode[4] && wakePending) begin
            core_next.mode = SMCU_MODE_NREQ;
            core_next.lpVddOff = 1'b0;
        end
        if (modeSetValid) begin
            core_next.mode = modeSetCode;
            core_next.lpVddOff = 1'b0;
        end
        if (core_next.mode == SMCU_MODE_NORMAL && core_reg.mode != SMCU_MODE_NORMAL) begin
            core_next.rndCode = core_reg.lfsr[2:0];
        end
        if (initMiscWrite && core_reg.mode == SMCU_MODE_INIT) begin
            core_next.rndProtect = initMiscRndSel;
        end
        // hardware set wins over a command clear
        if (debugSet) begin
            core_next.debug = 1'b1;
        end
        if (safeEngage) begin
            core_next.safeOff = 1'b0;
        end
        // snapshot only moves while no frame is running
        if (core_reg.csnSync[1]) begin
            core_next.snap.fix = fixStatus;
            core_next.snap.mode = core_reg.mode;
            core_next.snap.rnd = core_reg.rndCode;
            core_next.snap.safeOff = core_reg.safeOff;
            core_next.snap.debug = core_reg.debug;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            core_reg <= '0;
            core_reg.lfsr <= SMCU_LFSR_SEED;
            core_reg.rndCode <= SMCU_RND_RESET;
            core_reg.rndRead <= SMCU_RND_RESET;
            core_reg.csnSync <= 2'h3;
        end else begin
            core_reg <= core_next;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign currentMode = core_reg.mode;
    assign lowPowerMode = core_reg.mode[4];
    assign lpVddOff = core_reg.lpVddOff;
    assign forcedWakeup = core_reg.forced_wakeup;
    assign cyclicSense = core_reg.cyclic;
    assign safeDriverOn = !core_reg.safeOff;
    assign debugActive = core_reg.debug;
    assign rndProtect = core_reg.rndProtect;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    glb_debug_exit_a: assert property (
        (globalCmd && !cmd.b7 && !debugSet) |=> !debugActive)
        else $error("debug not left after global command");

    safe_release_a: assert property (
        (globalCmd && cmd.b7 && !safeEngage) |=> !safeDriverOn)
        else $error("safe pin not released");

    status_keep_debug_a: assert property (
        (globalCmd && cmd.kind == SMCU_KIND_STATUS && cmd.b7 && debugActive) |=> debugActive)
        else $error("debug lost on status release command");

    rnd_read_a: assert property (
        (globalCmd && cmd.kind == SMCU_KIND_PLAIN && currentMode == SMCU_MODE_NORMAL)
        |=> (core_reg.rndRead == $past(core_reg.rndCode)))
        else $error("random code read not recorded");

    lp_off_entry_a: assert property (
        (lpAccept && wrCode == 5'h0c && !modeSetValid)
        |=> (lowPowerMode && lpVddOff && !forcedWakeup && !cyclicSense))
        else $error("regulator-off low power not entered");

    rnd_guard_a: assert property (
        (writeCmd && rndProtect && currentMode == SMCU_MODE_NORMAL
            && cmd.low[2:0] != ~core_reg.rndRead && !modeSetValid)
        |=> (currentMode == SMCU_MODE_NORMAL))
        else $error("wrong code changed the mode");

    rnd_fresh_a: assert property (
        (currentMode != SMCU_MODE_NORMAL) ##1 (currentMode == SMCU_MODE_NORMAL)
        |-> (core_reg.rndCode == $past(core_reg.lfsr[2:0])))
        else $error("no fresh code at normal entry");

    prot_select_a: assert property (
        (currentMode != SMCU_MODE_INIT) |=> $stable(rndProtect))
        else $error("protection changed outside init");

    lp_wake_a: assert property (
        (lowPowerMode && wakePending && !modeSetValid) |=> (currentMode == SMCU_MODE_NREQ))
        else $error("pending wake did not leave low power");

    // ------------------------------------------------------------------
    // command, snapshot and priority checks
    // ------------------------------------------------------------------
    status_dbg_exit_a: assert property (
        (globalCmd && cmd.kind == SMCU_KIND_STATUS && !cmd.b7 && !debugSet) |=> !debugActive)
        else $error("debug not left on status command");

    safe_keep_a: assert property (
        (globalCmd && !cmd.b7 && !safeEngage) |=> $stable(safeDriverOn))
        else $error("safe pin moved on keep command");

    foreign_cmd_a: assert property (
        (newCmd && !isModeCmd(cmd) && !debugSet && !safeEngage)
        |=> ($stable(debugActive) && $stable(safeDriverOn)))
        else $error("foreign address changed debug or safe state");

    set_wins_a: assert property (
        debugSet |=> debugActive)
        else $error("debug set lost");

    engage_wins_a: assert property (
        safeEngage |=> safeDriverOn)
        else $error("safe engage lost");

    rnd_entry_a: assert property (
        (writeCmd && currentMode == SMCU_MODE_NORMAL && isLowPower(wrCode)
            && (!rndProtect || cmd.low[2:0] == ~core_reg.rndRead) && !modeSetValid)
        |=> lowPowerMode)
        else $error("matching code did not enter low power");

    lp_normal_only_a: assert property (
        (writeCmd && currentMode != SMCU_MODE_NORMAL && !lowPowerMode && !modeSetValid)
        |=> $stable(currentMode))
        else $error("low-power write accepted outside normal");

    vdd_on_entry_a: assert property (
        (lpAccept && wrCode[4] && !modeSetValid)
        |=> (lowPowerMode && !lpVddOff && forcedWakeup == $past(wrCode[3])))
        else $error("regulator-on low power not entered");

    snap_freeze_a: assert property (
        !core_reg.csnSync[1] |=> $stable(core_reg.snap))
        else $error("answer snapshot moved during a frame");

    snap_load_a: assert property (
        core_reg.csnSync[1]
        |=> (core_reg.snap.safeOff == $past(core_reg.safeOff)
            && core_reg.snap.debug == $past(core_reg.debug)))
        else $error("status snapshot not refreshed");

    snap_mode_a: assert property (
        core_reg.csnSync[1] |=> (core_reg.snap.mode == $past(currentMode)))
        else $error("mode snapshot not refreshed");

    rnd_snap_a: assert property (
        core_reg.csnSync[1] |=> (core_reg.snap.rnd == $past(core_reg.rndCode)))
        else $error("code snapshot not refreshed");

    prot_init_a: assert property (
        (initMiscWrite && currentMode == SMCU_MODE_INIT)
        |=> (rndProtect == $past(initMiscRndSel)))
        else $error("protection not taken in init");

    wake_spi_a: assert property (
        (writeCmd && lowPowerMode && wrCode == SMCU_MODE_NREQ && !modeSetValid)
        |=> (currentMode == SMCU_MODE_NREQ && !lpVddOff))
        else $error("spi wake did not reach normal request");

    lp_entry_c: cover property (lpAccept ##1 lowPowerMode);
    prot_entry_c: cover property (lpAccept && rndProtect);
    status_cmd_c: cover property (globalCmd && cmd.kind == SMCU_KIND_STATUS);
    safe_off_c: cover property (globalCmd && cmd.b7 ##1 !safeDriverOn);
    vdd_on_c: cover property (lpAccept && wrCode[4]);

endmodule : smcu_mode_cmd

// *** testbench/smcu_host_model.sv ***
// host-side spi master model for the mode command unit
`timescale 1ns/1ps

module smcu_host_model (
    // spi link
    output logic spiClk,
    output logic spiCsn,
    output logic spiMosi,
    input wire logic spiMiso
);
    // ------------
    // frame engine
    // ------------
    initial begin
        spiClk = 1'b0;
        spiCsn = 1'b1;
        spiMosi = 1'b1;
    end

    // msb first, 16 bits whole; clock idle low outside frames
    task automatic xfer(input logic [15:0] cmd, output logic [15:0] resp);
        resp = 16'h0000;
        #7;
        spiCsn = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            spiMosi = cmd[i];
            #15;
            resp = {resp[14:0], spiMiso};
            spiClk = 1'b1;
            #15;
            spiClk = 1'b0;
        end
        #15;
        spiCsn = 1'b1;
        // released line shows the inverse of its last bit
        spiMosi = ~spiMosi;
    endtask : xfer

endmodule : smcu_host_model

// *** testbench/tb_top.sv ***
// self-checking bench for the mode command unit
`timescale 1ns/1ps

module tb_top
    import smcu_pkg::*;
;
    logic clk, resetn, spiClk, spiCsn, spiMosi, spiMiso, spiMisoOen;
    logic [7:0] fixStatus;
    logic [4:0] modeSetCode, currentMode;
    logic modeSetValid, initMiscWrite, initMiscRndSel, wakePending, debugSet, safeEngage;
    logic lowPowerMode, lpVddOff, forcedWakeup, cyclicSense, safeDriverOn, debugActive;
    logic rndProtect;
    logic [15:0] resp;
    logic [2:0] code;
    int badCount = 0;
    int checked = 0;

    smcu_mode_cmd smcu_mode_cmd_inst (.clk(clk), .resetn(resetn), .spiClk(spiClk),
        .spiCsn(spiCsn), .spiMosi(spiMosi), .spiMiso(spiMiso), .spiMisoOen(spiMisoOen),
        .fixStatus(fixStatus), .modeSetValid(modeSetValid), .modeSetCode(modeSetCode),
        .initMiscWrite(initMiscWrite), .initMiscRndSel(initMiscRndSel),
        .wakePending(wakePending), .debugSet(debugSet), .safeEngage(safeEngage),
        .currentMode(currentMode), .lowPowerMode(lowPowerMode), .lpVddOff(lpVddOff),
        .forcedWakeup(forcedWakeup), .cyclicSense(cyclicSense),
        .safeDriverOn(safeDriverOn), .debugActive(debugActive), .rndProtect(rndProtect));

    smcu_host_model smcu_host_model_inst (.spiClk(spiClk), .spiCsn(spiCsn),
        .spiMosi(spiMosi), .spiMiso(spiMiso));

    initial clk = 1'b0;
    always #12.5 clk = ~clk;

    // ------------
    // helpers
    // ------------
    // mode, then lp, off, fwu, cyclic, safe, debug, protect, 0
    function automatic logic [15:0] st();
        return {3'h0, currentMode, lowPowerMode, lpVddOff, forcedWakeup, cyclicSense,
            safeDriverOn, debugActive, rndProtect, 1'b0};
    endfunction : st

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            badCount++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // output enable must be low at every rising link edge of a frame
    always @(posedge spiClk) begin
        check({15'h0, spiMisoOen}, 16'h0000);
    end

    task automatic completeRun();
        if (badCount == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : completeRun

    // host frame, then idle long enough for the command to land
    task automatic frame(input logic [15:0] cmd);
        smcu_host_model_inst.xfer(cmd, resp);
        repeat (8) @(negedge clk);
    endtask : frame

    task automatic setMode(input logic [4:0] m);
        @(negedge clk);
        modeSetValid = 1'b1;
        modeSetCode = m;
        @(negedge clk);
        modeSetValid = 1'b0;
        repeat (4) @(negedge clk);
    endtask : setMode

    task automatic strobe(input int which);
        @(negedge clk);
        if (which == 0) initMiscWrite = 1'b1;
        if (which == 1) debugSet = 1'b1;
        if (which == 2) safeEngage = 1'b1;
        if (which == 3) wakePending = 1'b1;
        @(negedge clk);
        {initMiscWrite, debugSet, safeEngage, wakePending} = 4'h0;
        repeat (4) @(negedge clk);
    endtask : strobe

    task automatic doReset();
        resetn = 1'b0;
        repeat (20) @(negedge clk);
        resetn = 1'b1;
        repeat (4) @(negedge clk);
    endtask : doReset

    // ------------
    // sequence
    // ------------
    initial begin
        {modeSetValid, initMiscWrite, wakePending, debugSet, safeEngage} = 5'h00;
        modeSetCode = 5'h00;
        initMiscRndSel = 1'b1;
        fixStatus = 8'ha5;
        doReset();
        check(st(), {3'h0, SMCU_MODE_INIT, 8'h08});
        setMode(SMCU_MODE_NORMAL);
        strobe(0);
        check(st(), {3'h0, SMCU_MODE_NORMAL, 8'h08});
        for (int m = 0; m < 4; m++) begin
            setMode(m[4:0]);
            frame(16'hdd00);
            check(resp, {8'ha5, m[4:0], 3'h0});
        end
        setMode(SMCU_MODE_INIT);
        strobe(0);
        setMode(SMCU_MODE_NORMAL);
        strobe(1);
        frame(16'hdd80);
        check(resp, {8'ha5, SMCU_MODE_NORMAL, 3'h1});
        check(st(), {3'h0, SMCU_MODE_NORMAL, 8'h06});
        frame(16'hdd00);
        check(resp, {8'ha5, SMCU_MODE_NORMAL, 3'h3});
        check(st(), {3'h0, SMCU_MODE_NORMAL, 8'h02});
        strobe(2);
        strobe(1);
        frame(16'h1d80);
        code = resp[2:0];
        check({resp[15:3], 3'h0}, {8'ha5, SMCU_MODE_NORMAL, 3'h0});
        check(st(), {3'h0, SMCU_MODE_NORMAL, 8'h06});
        frame(16'h1d00);
        check(resp, {8'ha5, SMCU_MODE_NORMAL, code});
        check(st(), {3'h0, SMCU_MODE_NORMAL, 8'h02});
        strobe(1);
        frame(16'h1b00);
        frame(16'h1c00);
        check(st(), {3'h0, SMCU_MODE_NORMAL, 8'h06});
        frame({13'b0101_1100_0110_0, ~code ^ 3'h1});
        check(st(), {3'h0, SMCU_MODE_NORMAL, 8'h06});
        frame({13'b0101_1100_0110_0, ~code});
        check(st(), {3'h0, 5'h1c, 8'hc6});
        frame(16'hdd00);
        check(resp, {8'ha5, 5'h1c, 3'h3});
        strobe(3);
        check({10'h0, currentMode, lowPowerMode}, {10'h0, SMCU_MODE_NREQ, 1'b0});
        doReset();
        setMode(SMCU_MODE_NORMAL);
        frame(16'h5c60);
        check(st(), {3'h0, 5'h1c, 8'hc8});
        frame(16'h5c10);
        check(st(), {3'h0, SMCU_MODE_NREQ, 8'h08});
        setMode(SMCU_MODE_NORMAL);
        frame(16'h5ce0);
        check(st(), {3'h0, 5'h1c, 8'hb8});
        strobe(3);
        setMode(SMCU_MODE_NORMAL);
        frame(16'h5c68);
        check(st(), {3'h0, 5'h1d, 8'hd8});
        completeRun();
    end

    initial begin
        #1500000;
        badCount++;
        completeRun();
    end

endmodule : tb_top
